// *** include/reset_cause_regs.svh ***
// Register map, flag masks and reset values of the reset cause block
`ifndef RESET_CAUSE_REGS_SVH
`define RESET_CAUSE_REGS_SVH

// Register indices on the plain register port
`define RC_ADDR_CAUSE    3'h0
`define RC_ADDR_STAT     3'h1
`define RC_ADDR_MASK     3'h2
`define RC_ADDR_SEGCTL   3'h3
`define RC_ADDR_BOOTLIM  3'h4
`define RC_ADDR_SECLIM   3'h5
`define RC_ADDR_INIT     3'h6

// Reset cause flags
`define RC_F_TRAP        16'h8000
`define RC_F_ILL         16'h4000
`define RC_F_MISM        16'h0200
`define RC_F_PIN         16'h0080
`define RC_F_SOFT        16'h0040
`define RC_F_WDOG        16'h0010
`define RC_F_SLEEP       16'h0008
`define RC_F_IDLE        16'h0004
`define RC_F_BROWN       16'h0002
`define RC_F_POR         16'h0001
`define RC_CAUSE_IMPL    16'hC2DF
`define RC_CAUSE_RST     16'h0003

// Event status bits
`define RC_EV_UNINIT     16'h0001
`define RC_EV_SEC        16'h0002
`define RC_EV_TRAP       16'h0004
`define RC_EV_WDOG       16'h0008
`define RC_EV_IMPL       16'h000F

// Segment control bits and limit layout
`define RC_SEG_BOOT_EN   16'h0001
`define RC_SEG_SEC_EN    16'h0002
`define RC_SEG_IMPL      16'h0003
`define RC_BOOT_BASE     24'h000000
`define RC_LIM_PAD       8'h00

// Working register bookkeeping
`define RC_SP_IDX        4'hF
`define RC_INIT_RST      16'h8000
`define RC_ZERO          16'h0000

`endif

// *** include/reset_cause_pkg.sv ***
// Shared types of the reset cause block
package reset_cause_pkg;
  typedef logic [15:0] word_t;
  typedef logic [23:0] paddr_t;
  typedef logic [3:0]  widx_t;
  typedef logic [2:0]  raddr_t;
endpackage : reset_cause_pkg

// *** src/reset_cause_flags.sv ***
// Reset cause register, uninitialised pointer and security reset logic
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "reset_cause_regs.svh"

module reset_cause_flags
  import reset_cause_pkg::*;
(
  input  wire logic   mclk_i,
  input  wire logic   rst_i,
  // Register port
  input  wire raddr_t reg_addr_i,
  input  wire word_t  reg_wdata_i,
  input  wire logic   reg_wr_i,
  input  wire logic   reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Reset sources
  input  wire logic   por_evt_i,
  input  wire logic   brown_out_reset_i,
  input  wire logic   master_clear_pin_n_i,
  input  wire logic   reset_instr_i,
  input  wire logic   watchdog_timeout_i,
  input  wire logic   watchdog_clear_instruction_i,
  input  wire logic   power_save_instruction_i,
  input  wire logic   power_save_idle_i,
  input  wire logic   trap_conflict_i,
  input  wire logic   illegal_opcode_i,
  input  wire logic   config_mismatch_i,
  // Core working register traffic
  input  wire logic   wreg_wr_i,
  input  wire widx_t  wreg_wr_idx_i,
  input  wire logic   ptr_use_i,
  input  wire widx_t  ptr_idx_i,
  // Program counter reloads
  input  wire logic   program_flow_change_i,
  input  wire logic   vector_flow_change_i,
  input  wire paddr_t flow_target_i,
  // Results
  output logic        dev_reset_o,
  output logic        wreg_clear_o,
  output logic        irq_o
);

  function automatic logic in_restricted(input paddr_t a, input paddr_t lo,
                                         input paddr_t hi);
    // Entry word of a segment stays reachable
    in_restricted = (a > lo) && (a < hi);
  endfunction : in_restricted

  function automatic word_t onehot16(input widx_t idx);
    onehot16 = word_t'(1) << idx;
  endfunction : onehot16

  word_t  cause_q;
  word_t  stat_q;
  word_t  mask_q;
  word_t  segctl_q;
  word_t  bootlim_q;
  word_t  seclim_q;
  word_t  init_q;
  word_t  rdata_q;
  logic   dev_reset_q;
  logic   wreg_clear_q;
  logic   irq_q;
  logic   pin_s1_q;
  logic   pin_s2_q;
  logic   pin_s3_q;

  // Address decode
  wire wr_cause   = reg_wr_i && (reg_addr_i == `RC_ADDR_CAUSE);
  wire wr_stat    = reg_wr_i && (reg_addr_i == `RC_ADDR_STAT);
  wire wr_mask    = reg_wr_i && (reg_addr_i == `RC_ADDR_MASK);
  wire wr_segctl  = reg_wr_i && (reg_addr_i == `RC_ADDR_SEGCTL);
  wire wr_bootlim = reg_wr_i && (reg_addr_i == `RC_ADDR_BOOTLIM);
  wire wr_seclim  = reg_wr_i && (reg_addr_i == `RC_ADDR_SECLIM);

  // Pin reset edge, taken from the second synchroniser stage onward
  wire pin_evt = pin_s3_q && !pin_s2_q;

  // Uninitialised working register used as a pointer
  wire uninit_hit = ptr_use_i && !init_q[ptr_idx_i];

  // Protected segment bounds
  wire paddr_t boot_lim = {bootlim_q, `RC_LIM_PAD};
  wire paddr_t sec_lim  = {seclim_q, `RC_LIM_PAD};
  wire boot_bad = ((segctl_q & `RC_SEG_BOOT_EN) != `RC_ZERO)
                  && in_restricted(flow_target_i, `RC_BOOT_BASE, boot_lim);
  wire sec_bad  = ((segctl_q & `RC_SEG_SEC_EN) != `RC_ZERO)
                  && in_restricted(flow_target_i, boot_lim, sec_lim);
  wire flow_chg = program_flow_change_i || vector_flow_change_i;
  wire sec_hit  = flow_chg && (boot_bad || sec_bad);

  wire ill_evt  = illegal_opcode_i || uninit_hit || sec_hit;
  wire pwr_sleep = power_save_instruction_i && !power_save_idle_i;
  wire pwr_idle  = power_save_instruction_i && power_save_idle_i;

  // Any cause that resets the core this cycle
  wire any_reset = por_evt_i || brown_out_reset_i || pin_evt || reset_instr_i
                   || watchdog_timeout_i || trap_conflict_i || config_mismatch_i
                   || ill_evt;

  // Hardware clears of the cause flags
  wire word_t clr_por  = por_evt_i ? `RC_CAUSE_IMPL : `RC_ZERO;
  // Brown-out keeps the pin and power-on flags
  wire word_t clr_brown = brown_out_reset_i ? (`RC_CAUSE_IMPL & ~(`RC_F_PIN | `RC_F_POR))
                                            : `RC_ZERO;
  wire word_t clr_wdog = (power_save_instruction_i || watchdog_clear_instruction_i)
                         ? `RC_F_WDOG : `RC_ZERO;
  wire word_t hw_clr   = clr_por | clr_brown | clr_wdog;

  // Hardware sets of the cause flags
  wire word_t set_por  = por_evt_i ? (`RC_F_POR | `RC_F_BROWN) : `RC_ZERO;
  wire word_t set_brown = brown_out_reset_i ? `RC_F_BROWN : `RC_ZERO;
  wire word_t set_trap = trap_conflict_i ? `RC_F_TRAP : `RC_ZERO;
  wire word_t set_ill  = ill_evt ? `RC_F_ILL : `RC_ZERO;
  wire word_t set_mism = config_mismatch_i ? `RC_F_MISM : `RC_ZERO;
  wire word_t set_pin  = pin_evt ? `RC_F_PIN : `RC_ZERO;
  wire word_t set_soft = reset_instr_i ? `RC_F_SOFT : `RC_ZERO;
  wire word_t set_wdog = watchdog_timeout_i ? `RC_F_WDOG : `RC_ZERO;
  wire word_t set_slp  = pwr_sleep ? `RC_F_SLEEP : `RC_ZERO;
  wire word_t set_idl  = pwr_idle ? `RC_F_IDLE : `RC_ZERO;
  wire word_t hw_set   = set_por | set_brown | set_trap | set_ill | set_mism
                         | set_pin | set_soft | set_wdog | set_slp | set_idl;

  // Software value first, then clears, then sets so a set wins
  wire word_t cause_wval = reg_wdata_i & `RC_CAUSE_IMPL;
  wire word_t cause_base = wr_cause ? cause_wval : cause_q;
  wire word_t cause_d    = ((cause_base & ~hw_clr) | hw_set)
                           & `RC_CAUSE_IMPL;

  // Event status, write one to clear, new event wins
  wire word_t ev_now = (uninit_hit ? `RC_EV_UNINIT : `RC_ZERO)
                       | (sec_hit ? `RC_EV_SEC : `RC_ZERO)
                       | (trap_conflict_i ? `RC_EV_TRAP : `RC_ZERO)
                       | (watchdog_timeout_i ? `RC_EV_WDOG : `RC_ZERO);
  wire word_t stat_clr = wr_stat ? reg_wdata_i : `RC_ZERO;
  wire word_t stat_d   = ((stat_q & ~stat_clr) | ev_now) & `RC_EV_IMPL;
  wire word_t mask_d   = wr_mask ? (reg_wdata_i & `RC_EV_IMPL) : mask_q;
  wire        irq_d    = (stat_d & mask_d) != `RC_ZERO;

  // Working register initialised marks
  wire word_t init_set = wreg_wr_i ? onehot16(wreg_wr_idx_i) : `RC_ZERO;
  wire word_t init_d   = any_reset ? `RC_INIT_RST : (init_q | init_set);

  // Read mux, unmapped addresses read zero
  wire word_t rd_mux =
      (reg_addr_i == `RC_ADDR_CAUSE)   ? cause_q   :
      (reg_addr_i == `RC_ADDR_STAT)    ? stat_q    :
      (reg_addr_i == `RC_ADDR_MASK)    ? mask_q    :
      (reg_addr_i == `RC_ADDR_SEGCTL)  ? segctl_q  :
      (reg_addr_i == `RC_ADDR_BOOTLIM) ? bootlim_q :
      (reg_addr_i == `RC_ADDR_SECLIM)  ? seclim_q  :
      (reg_addr_i == `RC_ADDR_INIT)    ? init_q    : `RC_ZERO;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else begin
      pin_s1_q <= master_clear_pin_n_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cause_q <= `RC_CAUSE_RST;
      stat_q  <= `RC_ZERO;
      mask_q  <= `RC_ZERO;
      irq_q   <= 1'b0;
    end else begin
      cause_q <= cause_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      irq_q   <= irq_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      segctl_q  <= `RC_ZERO;
      bootlim_q <= `RC_ZERO;
      seclim_q  <= `RC_ZERO;
    end else begin
      if (wr_segctl)  segctl_q  <= reg_wdata_i & `RC_SEG_IMPL;
      if (wr_bootlim) bootlim_q <= reg_wdata_i;
      if (wr_seclim)  seclim_q  <= reg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      init_q       <= `RC_INIT_RST;
      wreg_clear_q <= 1'b1;
      dev_reset_q  <= 1'b0;
      rdata_q      <= `RC_ZERO;
    end else begin
      init_q       <= init_d;
      wreg_clear_q <= any_reset;
      dev_reset_q  <= uninit_hit || sec_hit;
      rdata_q      <= reg_rd_i ? rd_mux : `RC_ZERO;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign dev_reset_o  = dev_reset_q;
  assign wreg_clear_o = wreg_clear_q;
  assign irq_o        = irq_q;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  wire no_hw = (hw_set == `RC_ZERO) && (hw_clr == `RC_ZERO);
  wire por_flag = (cause_q & `RC_F_POR) != `RC_ZERO;

  sequence bad_flow_s;
    flow_chg && sec_hit;
  endsequence

  sequence sec_reset_s;
    dev_reset_o && ((cause_q & `RC_F_ILL) != `RC_ZERO) && wreg_clear_o;
  endsequence

  sequence cause_read_s;
    reg_rd_i && (reg_addr_i == `RC_ADDR_CAUSE) && !reg_wr_i;
  endsequence

  uninit_reset_a: assert property (
    uninit_hit |=> dev_reset_o && wreg_clear_o
                   && ((cause_q & `RC_F_ILL) != `RC_ZERO))
    else $error("uninitialised pointer did not reset");

  sp_kept_a: assert property (
    init_q[`RC_SP_IDX])
    else $error("stack pointer marked uninitialised");

  init_clear_a: assert property (
    any_reset |=> (init_q == `RC_INIT_RST) && wreg_clear_o)
    else $error("working registers not marked after reset");

  sec_reset_a: assert property (
    bad_flow_s |=> sec_reset_s)
    else $error("restricted flow change without security reset");

  prog_flow_a: assert property (
    program_flow_change_i && boot_bad && !uninit_hit |=> dev_reset_o)
    else $error("program flow change not checked");

  vec_flow_a: assert property (
    vector_flow_change_i && sec_bad |=> dev_reset_o)
    else $error("vector flow change not checked");

  trap_flag_a: assert property (
    trap_conflict_i |=> (cause_q & `RC_F_TRAP) != `RC_ZERO)
    else $error("trap conflict flag not set");

  ill_flag_a: assert property (
    illegal_opcode_i |=> (cause_q & `RC_F_ILL) != `RC_ZERO)
    else $error("illegal opcode flag not set");

  mism_flag_a: assert property (
    config_mismatch_i |=> (cause_q & `RC_F_MISM) != `RC_ZERO)
    else $error("mismatch flag not set");

  pin_keep_a: assert property (
    brown_out_reset_i && !por_evt_i && !wr_cause
    && ((cause_q & `RC_F_PIN) != `RC_ZERO)
    |=> (cause_q & `RC_F_PIN) != `RC_ZERO)
    else $error("pin reset flag lost on brown-out");

  pin_flag_a: assert property (
    $fell(pin_s2_q) |=> (cause_q & `RC_F_PIN) != `RC_ZERO)
    else $error("pin reset flag not set");

  soft_flag_a: assert property (
    reset_instr_i |=> ((cause_q & `RC_F_SOFT) != `RC_ZERO) && wreg_clear_o)
    else $error("software reset flag not set");

  wdog_clear_a: assert property (
    (power_save_instruction_i || watchdog_clear_instruction_i)
    && !watchdog_timeout_i |=> (cause_q & `RC_F_WDOG) == `RC_ZERO)
    else $error("watchdog flag not cleared");

  sleep_idle_a: assert property (
    power_save_instruction_i && !watchdog_timeout_i
    |=> ((cause_q & `RC_F_WDOG) == `RC_ZERO)
        && ((cause_q & (`RC_F_IDLE | `RC_F_SLEEP)) != `RC_ZERO))
    else $error("power save flag mismatch");

  slp_flag_a: assert property (
    pwr_sleep |=> (cause_q & `RC_F_SLEEP) != `RC_ZERO)
    else $error("sleep flag not set");

  idle_flag_a: assert property (
    pwr_idle |=> (cause_q & `RC_F_IDLE) != `RC_ZERO)
    else $error("idle flag not set");

  por_flags_a: assert property (
    por_evt_i && ((hw_set & ~`RC_CAUSE_RST) == `RC_ZERO)
    |=> (cause_q & `RC_CAUSE_IMPL) == `RC_CAUSE_RST)
    else $error("power-on flags wrong");

  brown_flag_a: assert property (
    brown_out_reset_i && !por_evt_i && !wr_cause
    |=> $stable(por_flag) && ((cause_q & `RC_F_BROWN) != `RC_ZERO))
    else $error("brown-out flags wrong");

  sw_write_a: assert property (
    wr_cause && no_hw |=> cause_q == $past(cause_wval))
    else $error("software write of flags lost");

  reserved_zero_a: assert property (
    (cause_q & ~`RC_CAUSE_IMPL) == `RC_ZERO)
    else $error("reserved cause bit set");

  set_wins_a: assert property (
    wr_cause && watchdog_timeout_i |=> (cause_q & `RC_F_WDOG) != `RC_ZERO)
    else $error("hardware set lost to write");

  read_back_a: assert property (
    cause_read_s |=> reg_rdata_o == $past(cause_q))
    else $error("cause read returned wrong data");

endmodule : reset_cause_flags

// *** sim/core_source_model.sv ***
// Model of the core and the on-chip reset sources that feed the block
`timescale 1ns/1ps

module core_source_model
  import reset_cause_pkg::*;
(
  input  wire logic   mclk_i,
  output logic [12:0] ev_o,
  output widx_t       idx_o,
  output paddr_t      tgt_o,
  output logic        pin_n_o,
  output logic        idle_o
);
  initial begin
    ev_o    = 13'h0000;
    idx_o   = 4'h0;
    tgt_o   = 24'h000000;
    pin_n_o = 1'b1;
    idle_o  = 1'b0;
  end

  // One-cycle pulse; index and target turn over once released
  task automatic pulse(input logic [12:0] ev, input widx_t idx, input paddr_t tgt,
                       input logic idle);
    @(posedge mclk_i);
    ev_o   <= ev;
    idx_o  <= idx;
    tgt_o  <= tgt;
    idle_o <= idle;
    @(posedge mclk_i);
    ev_o  <= 13'h0000;
    idx_o <= ~idx;
    tgt_o <= ~tgt;
  endtask : pulse

  // Pin held low for n cycles
  task automatic pin_low(input int n);
    @(posedge mclk_i);
    pin_n_o <= 1'b0;
    repeat (n) @(posedge mclk_i);
    pin_n_o <= 1'b1;
  endtask : pin_low
endmodule : core_source_model

// *** sim/reset_cause_flags_tb.sv ***
// Self-checking bench of the reset cause block
`timescale 1ns/1ps
`include "reset_cause_regs.svh"

module reset_cause_flags_tb
  import reset_cause_pkg::*;
();
  localparam paddr_t BLIM = 24'h001000;
  localparam paddr_t SLIM = 24'h002000;
  logic        mclk_i;
  logic        rst_i;
  raddr_t      reg_addr_i;
  word_t       reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [15:0] reg_rdata_o;
  logic [12:0] ev;
  widx_t       idx;
  paddr_t      tgt;
  logic        pin_n;
  logic        idle;
  logic        dev_reset_o;
  logic        wreg_clear_o;
  logic        irq_o;
  int          n_mismatch;
  int          checked;
  int          cycles;
  word_t       cause;
  word_t       stat;
  word_t       init;
  widx_t       k;
  logic [31:0] r;
  logic [12:0] evs [12] = '{13'h0004, 13'h0008, 13'h0010, 13'h0008, 13'h0040, 13'h0080,
                            13'h0100, 13'h0020, 13'h0020, 13'h0002, 13'h0001, 13'h0002};
  logic [12:0] sev [5] = '{13'h0800, 13'h1000, 13'h0800, 13'h0800, 13'h1000};
  paddr_t      stg [5] = '{24'h000800, 24'h001800, 24'h000000, 24'h001000, 24'h002000};

  core_source_model core (.mclk_i(mclk_i), .ev_o(ev), .idx_o(idx), .tgt_o(tgt),
                          .pin_n_o(pin_n), .idle_o(idle));

  reset_cause_flags DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .por_evt_i(ev[0]), .brown_out_reset_i(ev[1]), .master_clear_pin_n_i(pin_n),
    .reset_instr_i(ev[2]), .watchdog_timeout_i(ev[3]), .watchdog_clear_instruction_i(ev[4]),
    .power_save_instruction_i(ev[5]), .power_save_idle_i(idle), .trap_conflict_i(ev[6]),
    .illegal_opcode_i(ev[7]), .config_mismatch_i(ev[8]), .wreg_wr_i(ev[9]),
    .wreg_wr_idx_i(idx), .ptr_use_i(ev[10]), .ptr_idx_i(idx),
    .program_flow_change_i(ev[11]), .vector_flow_change_i(ev[12]), .flow_target_i(tgt),
    .dev_reset_o(dev_reset_o), .wreg_clear_o(wreg_clear_o), .irq_o(irq_o));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic stop_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input raddr_t a, input word_t d);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input raddr_t a, input word_t exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask : rd

  function automatic logic hit(input paddr_t t);
    return (t > 24'h000000 && t < BLIM) || (t > BLIM && t < SLIM);
  endfunction : hit

  // Pulse events and check the reset outputs against the flag model
  task automatic fire(input logic [12:0] e, input widx_t i, input paddr_t t, input logic id);
    logic rs;
    rs = (e[10] && !init[i]) || ((e[11] || e[12]) && hit(t));
    core.pulse(e, i, t, id);
    #1;
    chk(16'(dev_reset_o), 16'(rs));
    chk(16'(wreg_clear_o), 16'(rs || (e & 13'h01CF) != 13'h0000));
    if (e[9]) init[i] = 1'b1;
    if (e[0]) cause = 16'h0003;
    if (e[1]) cause = (cause & 16'h0081) | 16'h0002;
    if (e[2]) cause |= 16'h0040;
    if (e[4] || e[5]) cause &= ~16'h0010;
    if (e[3]) cause |= 16'h0010;
    if (e[3]) stat |= 16'h0008;
    if (e[5]) cause |= id ? 16'h0004 : 16'h0008;
    if (e[6]) cause |= 16'h8000;
    if (e[6]) stat |= 16'h0004;
    if (e[7] || rs) cause |= 16'h4000;
    if (rs) stat |= e[10] ? 16'h0001 : 16'h0002;
    if (e[8]) cause |= 16'h0200;
    if (rs || (e & 13'h01CF) != 13'h0000) init = 16'h8000;
  endtask : fire

  initial begin
    reg_addr_i  = 3'h0;
    reg_wdata_i = 16'h0000;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    n_mismatch  = 0;
    checked     = 0;
    cycles      = 0;
    cause       = 16'h0003;
    stat        = 16'h0000;
    init        = 16'h8000;
    void'($urandom(32'h02B0));
    rst_i = 1'b1;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(`RC_ADDR_CAUSE, cause);
    rd(`RC_ADDR_INIT, init);
    rd(3'h7, 16'h0000);
    r = $urandom;
    wr(`RC_ADDR_CAUSE, r[15:0]);
    cause = r[15:0] & 16'hC2DF;
    rd(`RC_ADDR_CAUSE, cause);
    wr(`RC_ADDR_CAUSE, 16'h0000);
    core.pin_low(6);
    repeat (4) @(posedge mclk_i);
    cause = 16'h0080;
    init  = 16'h8000;
    rd(`RC_ADDR_CAUSE, cause);
    for (int i = 0; i < 12; i++) begin
      fire(evs[i], 4'h0, 24'h000000, i == 8);
      rd(`RC_ADDR_CAUSE, cause);
    end
    // Software clear in the same cycle as a trap conflict
    fork
      wr(`RC_ADDR_CAUSE, 16'h0000);
      core.pulse(13'h0040, 4'h0, 24'h000000, 1'b0);
    join
    cause = 16'h8000;
    init  = 16'h8000;
    rd(`RC_ADDR_CAUSE, cause);
    wr(`RC_ADDR_STAT, 16'h000F);
    stat = 16'h0000;
    k = widx_t'($urandom_range(14, 0));
    fire(13'h0400, k, 24'h000000, 1'b0);
    fire(13'h0200, k, 24'h000000, 1'b0);
    fire(13'h0400, k, 24'h000000, 1'b0);
    fire(13'h0400, `RC_SP_IDX, 24'h000000, 1'b0);
    rd(`RC_ADDR_INIT, init);
    rd(`RC_ADDR_CAUSE, cause);
    rd(`RC_ADDR_STAT, stat);
    chk(16'(irq_o), 16'h0000);
    wr(`RC_ADDR_MASK, 16'h0001);
    repeat (2) @(posedge mclk_i);
    chk(16'(irq_o), 16'h0001);
    wr(`RC_ADDR_STAT, 16'h0001);
    stat = 16'h0000;
    repeat (2) @(posedge mclk_i);
    chk(16'(irq_o), 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(`RC_ADDR_SEGCTL, 16'h0003);
      wr(`RC_ADDR_BOOTLIM, BLIM[23:8]);
      wr(`RC_ADDR_SECLIM, SLIM[23:8]);
      fire(sev[i], 4'h0, stg[i], 1'b0);
      rd(`RC_ADDR_CAUSE, cause);
    end
    stop_test();
  end
endmodule : reset_cause_flags_tb
